// [handler_ctrl_cfg.svh]
`ifndef HANDLER_CTRL_CFG_SVH
`define HANDLER_CTRL_CFG_SVH
// register word offsets (byte addresses)
`define OFS_PRIO_FAULT 8'h00
`define OFS_PRIO_SVC 8'h04
`define OFS_PRIO_TICK 8'h08
`define OFS_CTRL_STATE 8'h0c
`define OFS_CONFIG 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
// config register fields
`define CFG_TRIG_BIT 1
`define CFG_THREAD_BIT 0
// control and state fields
`define CS_USG_EN_BIT 18
`define CS_BUS_EN_BIT 17
`define CS_MEM_EN_BIT 16
`define CS_SVC_PEND_BIT 15
`define CS_BUS_PEND_BIT 14
`define CS_MEM_PEND_BIT 13
`define CS_USG_PEND_BIT 12
`define CS_TICK_ACT_BIT 11
`define CS_PSV_ACT_BIT 10
`define CS_MON_ACT_BIT 8
`define CS_SVC_ACT_BIT 7
`define CS_USG_ACT_BIT 3
`define CS_BUS_ACT_BIT 1
`define CS_MEM_ACT_BIT 0
`define CS_WRITE_MASK 32'h0007fd8b
// priority storage: upper nibble of each implemented byte lane
`define PRIO_MASK_FAULT 32'h00f0f0f0
`define PRIO_MASK_SVC 32'hf0000000
`define PRIO_MASK_TICK 32'hf0f00000
`define RESET_ZERO 32'h00000000
// interrupt status bits
`define IRQ_ESCALATE_BIT 0
`define IRQ_TRIG_DENY_BIT 1
`define IRQ_THREAD_DENY_BIT 2
`endif

// [handler_ctrl_pkg.sv]
`default_nettype none
package handler_ctrl_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0] prio_t;
  typedef enum {st_run, st_escalate} fault_state_t;
endpackage
`default_nettype wire

// [handler_irq_unit.sv]
`default_nettype none
`include "handler_ctrl_cfg.svh"
module handler_irq_unit
  import handler_ctrl_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);
  // refused at elaboration: status and mask must fit one register word
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("bad WIDTH");
  end
  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
  } irq_state_t;
  irq_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    // a new event beats a write-one clear in the same cycle
    if (wr_status) begin
      s_d.status = s_q.status & ~wdata;
    end
    s_d.status = s_d.status | event_in;
    if (wr_mask) begin
      s_d.mask = wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign status = s_q.status;
  assign mask = s_q.mask;
  assign irq = |(s_q.status & s_q.mask);
endmodule // handler_irq_unit
`default_nettype wire

// [system_handler_prio_ctrl.sv]
// Decided for this implementation: strobed register access and the register offsets.
`default_nettype none
`include "handler_ctrl_cfg.svh"
module system_handler_prio_ctrl
  import handler_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wbe,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic trig_req,
  input wire logic trig_privileged,
  output logic trig_grant,
  input wire logic thread_ret_req,
  output logic thread_ret_ok,
  input wire logic mem_fault_evt,
  input wire logic bus_fault_evt,
  input wire logic usage_fault_evt,
  output logic hard_fault,
  output logic [3:0] memory_fault_priority,
  output logic [3:0] bus_error_priority,
  output logic [3:0] usage_error_priority,
  output logic [3:0] supervisor_call_priority,
  output logic [3:0] pendable_service_priority,
  output logic [3:0] system_tick_priority,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    word_t prio_fault;
    word_t prio_svc;
    word_t prio_tick;
    word_t ctrl_state;
    logic trig_enable;
    logic thread_any;
    word_t rdata;
    logic hard_fault;
    fault_state_t fstate;
  } ctrl_state_t;

  ctrl_state_t s_q, s_d;

  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_events;
  logic escalate;
  logic any_active;

  // byte-lane merge, keeping only bits that exist
  function automatic word_t lane_write(input word_t old, input word_t nv, input logic [3:0] be,
                                       input word_t keep);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    lane_write = r & keep;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fault escalation and mode checks

  always_comb begin
    escalate = 1'b0;
    if (mem_fault_evt && !s_q.ctrl_state[`CS_MEM_EN_BIT]) begin
      escalate = 1'b1;
    end
    if (bus_fault_evt && !s_q.ctrl_state[`CS_BUS_EN_BIT]) begin
      escalate = 1'b1;
    end
    if (usage_fault_evt && !s_q.ctrl_state[`CS_USG_EN_BIT]) begin
      escalate = 1'b1;
    end
  end

  assign any_active = s_q.ctrl_state[`CS_TICK_ACT_BIT] | s_q.ctrl_state[`CS_PSV_ACT_BIT]
                    | s_q.ctrl_state[`CS_MON_ACT_BIT] | s_q.ctrl_state[`CS_SVC_ACT_BIT]
                    | s_q.ctrl_state[`CS_USG_ACT_BIT] | s_q.ctrl_state[`CS_BUS_ACT_BIT]
                    | s_q.ctrl_state[`CS_MEM_ACT_BIT];

  // handshake outputs are combinational on purpose: the core asks and acts in one cycle
  assign trig_grant = trig_req & (trig_privileged | s_q.trig_enable);
  assign thread_ret_ok = thread_ret_req & (s_q.thread_any | !any_active);

  assign irq_events[`IRQ_ESCALATE_BIT] = escalate;
  assign irq_events[`IRQ_TRIG_DENY_BIT] = trig_req & !trig_grant;
  assign irq_events[`IRQ_THREAD_DENY_BIT] = thread_ret_req & !thread_ret_ok;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    if (wr_en) begin
      case (addr)
        `OFS_PRIO_FAULT: begin
          s_d.prio_fault = lane_write(s_q.prio_fault, wdata, wbe, `PRIO_MASK_FAULT);
        end
        `OFS_PRIO_SVC: begin
          s_d.prio_svc = lane_write(s_q.prio_svc, wdata, wbe, `PRIO_MASK_SVC);
        end
        `OFS_PRIO_TICK: begin
          s_d.prio_tick = lane_write(s_q.prio_tick, wdata, wbe, `PRIO_MASK_TICK);
        end
        `OFS_CTRL_STATE: begin
          // enables, pending and active all writable; reserved bits dropped
          s_d.ctrl_state = lane_write(s_q.ctrl_state, wdata, wbe, `CS_WRITE_MASK);
        end
        `OFS_CONFIG: begin
          if (wbe[0]) begin
            s_d.trig_enable = wdata[`CFG_TRIG_BIT];
            s_d.thread_any = wdata[`CFG_THREAD_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      case (addr)
        `OFS_PRIO_FAULT: s_d.rdata = s_q.prio_fault;
        `OFS_PRIO_SVC: s_d.rdata = s_q.prio_svc;
        `OFS_PRIO_TICK: s_d.rdata = s_q.prio_tick;
        `OFS_CTRL_STATE: s_d.rdata = s_q.ctrl_state;
        `OFS_CONFIG: begin
          s_d.rdata[`CFG_TRIG_BIT] = s_q.trig_enable;
          s_d.rdata[`CFG_THREAD_BIT] = s_q.thread_any;
        end
        `OFS_IRQ_STATUS: s_d.rdata = {29'h0, irq_status};
        `OFS_IRQ_MASK: s_d.rdata = {29'h0, irq_mask};
        default: s_d.rdata = '0;
      endcase
    end
    // escalation shows as hard fault one cycle later, held for as long as escalation lasts
    case (s_q.fstate)
      st_run: begin
        s_d.hard_fault = escalate;
        s_d.fstate = escalate ? st_escalate : st_run;
      end
      st_escalate: begin
        s_d.hard_fault = escalate;
        s_d.fstate = escalate ? st_escalate : st_run;
      end
      default: begin
        s_d.hard_fault = 1'b0;
        s_d.fstate = st_run;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{prio_fault: `RESET_ZERO, prio_svc: `RESET_ZERO, prio_tick: `RESET_ZERO,
               ctrl_state: `RESET_ZERO, trig_enable: 1'b0, thread_any: 1'b0,
               rdata: `RESET_ZERO, hard_fault: 1'b0, fstate: st_run};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  handler_irq_unit #(.WIDTH(3)) u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .event_in(irq_events),
    .wr_status(wr_en && addr == `OFS_IRQ_STATUS && wbe[0]),
    .wr_mask(wr_en && addr == `OFS_IRQ_MASK && wbe[0]),
    .wdata(wdata[2:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = s_q.rdata;
  assign hard_fault = s_q.hard_fault;
  assign memory_fault_priority = s_q.prio_fault[7:4];
  assign bus_error_priority = s_q.prio_fault[15:12];
  assign usage_error_priority = s_q.prio_fault[23:20];
  assign supervisor_call_priority = s_q.prio_svc[31:28];
  assign pendable_service_priority = s_q.prio_tick[23:20];
  assign system_tick_priority = s_q.prio_tick[31:28];

endmodule // system_handler_prio_ctrl
`default_nettype wire

// [system_handler_prio_ctrl_assertions.sv]
`default_nettype none
module shpc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wbe,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic trig_req,
  input wire logic trig_privileged,
  input wire logic trig_grant,
  input wire logic thread_ret_req,
  input wire logic thread_ret_ok,
  input wire logic mem_fault_evt,
  input wire logic bus_fault_evt,
  input wire logic usage_fault_evt,
  input wire logic hard_fault,
  input wire logic [3:0] memory_fault_priority,
  input wire logic [3:0] supervisor_call_priority,
  input wire logic [3:0] system_tick_priority
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_grant_priv: assert property (trig_req && trig_privileged |-> trig_grant)
    else $error("privileged trigger refused");
  a_grant_idle: assert property (!trig_req |-> !trig_grant)
    else $error("grant without request");
  a_thread_idle: assert property (!thread_ret_req |-> !thread_ret_ok)
    else $error("thread ok without request");
  a_hard_cause: assert property (hard_fault |-> $past(mem_fault_evt) || $past(bus_fault_evt) || $past(usage_fault_evt))
    else $error("hard fault without event");
  a_rd_quiet: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_fault_rsvd: assert property ($past(rd_en) && $past(addr) == 8'h00 |-> (rdata & 32'hff0f0f0f) == 32'h0)
    else $error("priority low nibble not zero");
  a_ctrl_rsvd: assert property ($past(rd_en) && $past(addr) == 8'h0c |-> (rdata & 32'hfff80274) == 32'h0)
    else $error("control reserved bit set");
  a_mem_prio_wr: assert property (wr_en && addr == 8'h00 && wbe[0] |=> memory_fault_priority == $past(wdata[7:4]))
    else $error("memory fault priority not stored");
  a_svc_prio_wr: assert property (wr_en && addr == 8'h04 && wbe[3] |=> supervisor_call_priority == $past(wdata[31:28]))
    else $error("call priority not stored");
  a_tick_prio_wr: assert property (wr_en && addr == 8'h08 && wbe[3] |=> system_tick_priority == $past(wdata[31:28]))
    else $error("tick priority not stored");
endmodule // shpc_checker
bind system_handler_prio_ctrl shpc_checker chk_u (.*);
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wbe = 4'h0;
  logic wr_en = 1'b0, rd_en = 1'b0, trig_req = 1'b0, trig_privileged = 1'b0, thread_ret_req = 1'b0;
  logic mem_fault_evt = 1'b0, bus_fault_evt = 1'b0, usage_fault_evt = 1'b0;
  logic [31:0] rdata;
  logic trig_grant, thread_ret_ok, hard_fault, irq;
  logic [3:0] p_mem, p_bus, p_usg, p_svc, p_psv, p_tick;
  int err_total = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  system_handler_prio_ctrl dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wbe(wbe),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .trig_req(trig_req), .trig_privileged(trig_privileged),
    .trig_grant(trig_grant), .thread_ret_req(thread_ret_req), .thread_ret_ok(thread_ret_ok),
    .mem_fault_evt(mem_fault_evt), .bus_fault_evt(bus_fault_evt), .usage_fault_evt(usage_fault_evt),
    .hard_fault(hard_fault), .memory_fault_priority(p_mem), .bus_error_priority(p_bus),
    .usage_error_priority(p_usg), .supervisor_call_priority(p_svc), .pendable_service_priority(p_psv),
    .system_tick_priority(p_tick), .irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wbe <= be;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask
  // one-cycle event pulse; escalation shows the cycle after
  task fire(input int i, input logic e);
    @(posedge clk);
    {usage_fault_evt, bus_fault_evt, mem_fault_evt} <= 3'b001 << i;
    @(posedge clk);
    {usage_fault_evt, bus_fault_evt, mem_fault_evt} <= 3'b000;
    #1;
    chk("hard_fault", {31'h0, hard_fault}, {31'h0, e});
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    err_total++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (logic [7:0] a = 8'h00; a < 8'h1c; a += 8'h04) rd(a, 32'h0, "reset value");
    $display("test reset done");
    wr(8'h00, 32'hffffffff, 4'hf);
    wr(8'h04, 32'hffffffff, 4'hf);
    wr(8'h08, 32'hffffffff, 4'hf);
    rd(8'h00, 32'h00f0f0f0, "fault prio");
    rd(8'h04, 32'hf0000000, "call prio");
    rd(8'h08, 32'hf0f00000, "tick prio");
    chk("prio outs", {8'h0, p_tick, p_psv, p_svc, p_usg, p_bus, p_mem}, 32'h00ffffff);
    wr(8'h00, 32'h0, 4'h2);
    rd(8'h00, 32'h00f000f0, "byte lane");
    wr(8'h00, 32'h00a05030, 4'hf);
    chk("fault outs", {20'h0, p_usg, p_bus, p_mem}, 32'h00000a53);
    wr(8'hfc, 32'hffffffff, 4'hf);
    rd(8'hfc, 32'h0, "unmapped");
    $display("test priority done");
    wr(8'h0c, 32'hffffffff, 4'hf);
    rd(8'h0c, 32'h0007fd8b, "ctrl word");
    wr(8'h0c, 32'h0, 4'hf);
    wr(8'h18, 32'h1, 4'h1);
    for (int i = 0; i < 3; i++) begin
      fire(i, 1'b1);
      chk("irq set", {31'h0, irq}, 32'h1);
      wr(8'h14, 32'h1, 4'h1);
      chk("irq clear", {31'h0, irq}, 32'h0);
    end
    // enabled handlers take their own faults, no escalation
    wr(8'h0c, 32'h00070000, 4'hf);
    for (int i = 0; i < 3; i++) fire(i, 1'b0);
    rd(8'h14, 32'h0, "no escalation");
    // handlers now enabled: a single bit changes only by read, modify, write
    rd(8'h0c, 32'h00070000, "rmw read");
    wr(8'h0c, 32'h00072000, 4'hf);
    rd(8'h0c, 32'h00072000, "rmw result");
    $display("test faults done");
    @(posedge clk);
    trig_req <= 1'b1;
    #1;
    chk("unpriv grant", {31'h0, trig_grant}, 32'h0);
    @(posedge clk);
    trig_privileged <= 1'b1;
    #1;
    chk("priv grant", {31'h0, trig_grant}, 32'h1);
    @(posedge clk);
    trig_privileged <= 1'b0;
    wr(8'h10, 32'h2, 4'h1);
    chk("enabled grant", {31'h0, trig_grant}, 32'h1);
    rd(8'h14, 32'h2, "trig denied");
    wr(8'h10, 32'h0, 4'h1);
    $display("test trigger done");
    @(posedge clk);
    trig_req <= 1'b0;
    thread_ret_req <= 1'b1;
    #1;
    chk("thread idle", {31'h0, thread_ret_ok}, 32'h1);
    wr(8'h0c, 32'h00072800, 4'hf);
    chk("thread busy", {31'h0, thread_ret_ok}, 32'h0);
    wr(8'h10, 32'h1, 4'h1);
    chk("thread any", {31'h0, thread_ret_ok}, 32'h1);
    rd(8'h14, 32'h6, "thread denied");
    // saved active status put back once the switch is over
    wr(8'h0c, 32'h00072000, 4'hf);
    rd(8'h0c, 32'h00072000, "active restored");
    $display("test thread done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h0c, 32'h0, "ctrl after reset");
    rd(8'h10, 32'h0, "config after reset");
    chk("prio after reset", {8'h0, p_tick, p_psv, p_svc, p_usg, p_bus, p_mem}, 32'h0);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
